/* src/pstu_map.vh */
`ifndef PSTU_MAP_VH
`define PSTU_MAP_VH
// ==========================================
// data and store geometry
`define PSTU_DATA_W        32
`define PSTU_ID_W          8
`define PSTU_DEPTH         256
// last index of the load and commit sweeps
`define PSTU_LAST_IDX      8'hFF
// ==========================================
// update classes
`define PSTU_CLASS_A       2'h0
`define PSTU_CLASS_B       2'h1
`define PSTU_CLASS_C       2'h2
`define PSTU_CLASS_D       2'h3
// ==========================================
// maintenance command codes
`define PSTU_CMD_CONFIG    16'h00C6
`define PSTU_CMD_COMMIT    16'h00C9
// ==========================================
// alarm codes
`define PSTU_ALARM_NONE    8'h00
`define PSTU_ALARM_MEMERR  8'h41
`endif

/* src/pstu_param_store.v */
`timescale 1ns/100ps
`include "pstu_map.vh"
// Function
// - every parameter is held as a 32-bit word in both working and non-volatile stores.
// - the working store is lost at power-down while the non-volatile store survives.
// - at power-up all parameters are copied from non-volatile to working store, then set up.
// - a write by parameter identifier changes only the working store.
// - the host issues the commit command and the device then writes working into non-volatile.
// - a non-volatile write cut short by power loss raises memory-error alarm code 41h.
// - a class A write is recalculated and set up at once.
// - a class B write is set up only once motor operation has stopped.
// - a class C write is set up only after the configuration command or a power cycle.
// - a class D write is set up only after a full power cycle.
// - the configuration command recalculates and sets up the working store.
// - the commit command copies the working store into non-volatile storage.
// - configuration is accepted only with no alarm, motor idle and no batch command running.
module pstu_param_store (
  // clock and reset
  input  wire        clk_in,
  input  wire        rst_b_in,
  // power-up load request (level, from power supervisor)
  input  wire        power_up_in,
  // power-fail warning (asynchronous pin)
  input  wire        power_fail_in,
  // host parameter write
  input  wire        wr_req_in,
  input  wire [7:0]  wr_id_in,
  input  wire [31:0] wr_data_in,
  input  wire [1:0]  wr_class_in,
  // host parameter read of working store
  input  wire [7:0]  rd_id_in,
  // maintenance command
  input  wire        cmd_req_in,
  input  wire [15:0] cmd_code_in,
  // drive status
  input  wire        motor_run_in,
  input  wire        alarm_in,
  // results
  output reg  [31:0] rd_data_out,
  output reg         wr_done_out,
  output reg         cmd_ack_out,
  output reg         cmd_rej_out,
  output reg         busy_out,
  output reg         setup_out,
  output reg  [1:0]  setup_class_out,
  output reg  [7:0]  alarm_code_out
);

  // ==========================================
  // states
  localparam [3:0] ST_IDLE   = 4'b0001;
  localparam [3:0] ST_LOAD   = 4'b0010;
  localparam [3:0] ST_COMMIT = 4'b0100;
  localparam [3:0] ST_DONE   = 4'b1000;

  // ==========================================
  // stores
  reg [`PSTU_DATA_W-1:0] work_mem [0:`PSTU_DEPTH-1];
  reg [`PSTU_DATA_W-1:0] nv_mem   [0:`PSTU_DEPTH-1];

  reg [3:0] state;
  reg [7:0] idx;
  reg       pf_meta;
  reg       pf_sync;
  reg       pu_meta;
  reg       pu_sync;
  reg       pu_seen;
  reg       pend_b;
  reg       pend_c;

  wire cmd_cfg    = cmd_req_in && (cmd_code_in == `PSTU_CMD_CONFIG);
  wire cmd_commit = cmd_req_in && (cmd_code_in == `PSTU_CMD_COMMIT);
  wire idle       = (state == ST_IDLE);
  wire load_go    = pu_sync && !pu_seen;
  wire mem_alarm  = (alarm_code_out != `PSTU_ALARM_NONE);
  // a write that meets the load, a commit or a configuration command is dropped whole, never half taken
  wire wr_take    = idle && wr_req_in && !load_go && !cmd_commit && !cmd_cfg;
  // batch memory commands cannot overlap a running commit or load
  wire cfg_ok     = idle && !alarm_in && !mem_alarm && !motor_run_in;

  // ==========================================
  // pin synchronisers
  always @(posedge clk_in) begin
    if (!rst_b_in) begin
      pf_meta <= 1'b0;
      pf_sync <= 1'b0;
      pu_meta <= 1'b0;
      pu_sync <= 1'b0;
    end else begin
      pf_meta <= power_fail_in;
      pf_sync <= pf_meta;
      pu_meta <= power_up_in;
      pu_sync <= pu_meta;
    end
  end

  // ==========================================
  // memory writes: host writes only to working store, nv only on commit
  always @(posedge clk_in) begin
    if (state == ST_LOAD)
      work_mem[idx] <= nv_mem[idx];
    else if (wr_take)
      work_mem[wr_id_in] <= wr_data_in;
    if (state == ST_COMMIT && !pf_sync)
      nv_mem[idx] <= work_mem[idx];
  end

  // ==========================================
  // host read port, one cycle behind the index
  always @(posedge clk_in) begin
    if (!rst_b_in)
      rd_data_out <= 32'h0000_0000;
    else
      rd_data_out <= work_mem[rd_id_in];
  end

  // ==========================================
  // memory-error alarm stays until reset so a cut commit is never missed
  always @(posedge clk_in) begin
    if (!rst_b_in)
      alarm_code_out <= `PSTU_ALARM_NONE;
    else if (state == ST_COMMIT && pf_sync)
      alarm_code_out <= `PSTU_ALARM_MEMERR;
  end

  // ==========================================
  // sequencing
  always @(posedge clk_in) begin
    if (!rst_b_in) begin
      state           <= ST_IDLE;
      idx             <= 8'h00;
      pu_seen         <= 1'b0;
      pend_b          <= 1'b0;
      pend_c          <= 1'b0;
      wr_done_out     <= 1'b0;
      cmd_ack_out     <= 1'b0;
      cmd_rej_out     <= 1'b0;
      busy_out        <= 1'b0;
      setup_out       <= 1'b0;
      setup_class_out <= `PSTU_CLASS_A;
    end else begin
      wr_done_out <= 1'b0;
      cmd_ack_out <= 1'b0;
      cmd_rej_out <= 1'b0;
      setup_out   <= 1'b0;
      case (state)
        ST_IDLE: begin
          busy_out <= 1'b0;
          if (load_go) begin
            // class D values take effect only here; every other class is reloaded here too
            pu_seen  <= 1'b1;
            idx      <= 8'h00;
            busy_out <= 1'b1;
            state    <= ST_LOAD;
          end else if (cmd_commit) begin
            cmd_ack_out <= 1'b1;
            idx         <= 8'h00;
            busy_out    <= 1'b1;
            state       <= ST_COMMIT;
          end else if (cmd_cfg) begin
            if (cfg_ok) begin
              cmd_ack_out     <= 1'b1;
              setup_out       <= 1'b1;
              setup_class_out <= `PSTU_CLASS_C;
              pend_c          <= 1'b0;
            end else
              cmd_rej_out <= 1'b1;
          end else if (wr_take) begin
            wr_done_out <= 1'b1;
            case (wr_class_in)
              `PSTU_CLASS_A: begin
                setup_out       <= 1'b1;
                setup_class_out <= `PSTU_CLASS_A;
              end
              `PSTU_CLASS_B: pend_b <= 1'b1;
              `PSTU_CLASS_C: pend_c <= 1'b1;
              default: ; // class D waits for power cycle
            endcase
          end else if (pend_b && !motor_run_in) begin
            // stop edge or already idle: apply once
            setup_out       <= 1'b1;
            setup_class_out <= `PSTU_CLASS_B;
            pend_b          <= 1'b0;
          end
        end
        ST_LOAD: begin
          busy_out <= 1'b1;
          idx      <= idx + 8'h01;
          // config or commit over a half-loaded store would act on stale words
          if (cmd_req_in)
            cmd_rej_out <= 1'b1;
          if (idx == `PSTU_LAST_IDX) begin
            setup_out       <= 1'b1;
            setup_class_out <= `PSTU_CLASS_D;
            pend_b          <= 1'b0;
            pend_c          <= 1'b0;
            state           <= ST_DONE;
          end
        end
        ST_COMMIT: begin
          busy_out <= 1'b1;
          if (cmd_req_in)
            cmd_rej_out <= 1'b1;
          if (pf_sync) begin
            state <= ST_DONE;
          end else begin
            idx <= idx + 8'h01;
            if (idx == `PSTU_LAST_IDX)
              state <= ST_DONE;
          end
        end
        ST_DONE: begin
          busy_out <= 1'b0;
          if (cmd_req_in)
            cmd_rej_out <= 1'b1;
          state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

endmodule // pstu_param_store

/* bench/pstu_host.sv */
`timescale 1ns/100ps
// ====
// host model: one-cycle write and command pulses
module pstu_host (
  // clock
  input  wire        clk_in,
  // requests
  output reg         wr_req_out = 1'b0,
  output reg  [7:0]  wr_id_out = 8'h00,
  output reg  [31:0] wr_data_out = 32'h0000_0000,
  output reg  [1:0]  wr_class_out = 2'h0,
  output reg         cmd_req_out = 1'b0,
  output reg  [15:0] cmd_code_out = 16'h0000
);
  // released id, data and command code lines show the inverse, so stale data never looks valid; the class lines keep their value
  task wr(input [7:0] i, input [31:0] d, input [1:0] c);
    @(posedge clk_in) {wr_req_out, wr_id_out, wr_data_out, wr_class_out} <= {1'b1, i, d, c};
    @(posedge clk_in) {wr_req_out, wr_id_out, wr_data_out} <= {1'b0, ~i, ~d};
  endtask
  task cmd(input [15:0] c);
    @(posedge clk_in) {cmd_req_out, cmd_code_out} <= {1'b1, c};
    @(posedge clk_in) {cmd_req_out, cmd_code_out} <= {1'b0, ~c};
  endtask
endmodule // pstu_host

/* bench/pstu_param_store_properties.sv */
`timescale 1ns/100ps
// ====
// port checks
module pstu_chk (
  // clock and reset
  input wire        clk_in, rst_b_in,
  // requests and status
  input wire        wr_req_in, cmd_req_in, motor_run_in, alarm_in,
  input wire [1:0]  wr_class_in,
  input wire [15:0] cmd_code_in,
  // results
  input wire        wr_done_out, cmd_ack_out, cmd_rej_out, busy_out, setup_out,
  input wire [1:0]  setup_class_out,
  input wire [7:0]  alarm_code_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  wire wr_ok = wr_req_in && !busy_out && !cmd_req_in;
  wire cfg = cmd_req_in && cmd_code_in == 16'h00C6;
  // the block's own memory error counts as an active alarm
  wire cfg_bad = alarm_in || motor_run_in || busy_out || alarm_code_out != 8'h00;
  AST_WR_A: assert property (wr_ok && wr_class_in == 2'h0
    |=> wr_done_out && setup_out && setup_class_out == 2'h0) else $error("class A late");
  AST_WR_B: assert property (wr_ok && wr_class_in == 2'h1 && motor_run_in
    |=> wr_done_out && !setup_out) else $error("class B early");
  AST_WR_CD: assert property (wr_ok && wr_class_in[1]
    |=> wr_done_out && !setup_out) else $error("class C/D early");
  AST_CFG_REJ: assert property (cfg && cfg_bad
    |=> cmd_rej_out && !cmd_ack_out) else $error("config not refused");
  AST_CFG_OK: assert property (cfg && !cfg_bad
    |=> cmd_ack_out && setup_out && setup_class_out == 2'h2) else $error("config not run");
  AST_COMMIT: assert property (cmd_req_in && cmd_code_in == 16'h00C9 && !busy_out
    |=> cmd_ack_out ##0 busy_out [*8] ##[1:270] !busy_out) else $error("commit timing");
  AST_BUSY_REJ: assert property (cmd_req_in && busy_out |=> cmd_rej_out)
    else $error("command taken while busy");
  AST_ALARM: assert property (alarm_code_out == 8'h41 |=> $stable(alarm_code_out))
    else $error("alarm not sticky");
endmodule // pstu_chk

bind pstu_param_store pstu_chk u_chk (.clk_in(clk_in), .rst_b_in(rst_b_in),
  .wr_req_in(wr_req_in), .cmd_req_in(cmd_req_in), .motor_run_in(motor_run_in),
  .alarm_in(alarm_in), .wr_class_in(wr_class_in), .cmd_code_in(cmd_code_in),
  .wr_done_out(wr_done_out), .cmd_ack_out(cmd_ack_out), .cmd_rej_out(cmd_rej_out),
  .busy_out(busy_out), .setup_out(setup_out), .setup_class_out(setup_class_out),
  .alarm_code_out(alarm_code_out));

/* bench/testbench.sv */
`timescale 1ns/100ps
// ====
// bench
module testbench;
  typedef struct packed {logic [7:0] id; logic [31:0] d; logic [1:0] c; logic su;} pstu_row_t;
  pstu_row_t  rows [3] = '{'{8'h10, 32'h1234_5678, 2'h0, 1'b1},
    '{8'h11, 32'hFFFF_0000, 2'h2, 1'b0}, '{8'hFF, 32'hA5A5_5A5A, 2'h3, 1'b0}};
  reg         clk_in = 0, rst_b_in = 0, power_up_in = 1, power_fail_in = 0;
  reg         motor_run_in = 0, alarm_in = 0;
  reg  [7:0]  rd_id_in = 8'h00;
  wire        wr_req_in, cmd_req_in, wr_done_out, cmd_ack_out, cmd_rej_out, busy_out, setup_out;
  wire [7:0]  wr_id_in, alarm_code_out;
  wire [31:0] wr_data_in, rd_data_out;
  wire [1:0]  wr_class_in, setup_class_out;
  wire [15:0] cmd_code_in;
  integer     checks = 0, miscompares = 0, cycles = 0, i, k;
  pstu_host host (.clk_in(clk_in), .wr_req_out(wr_req_in), .wr_id_out(wr_id_in),
    .wr_data_out(wr_data_in), .wr_class_out(wr_class_in), .cmd_req_out(cmd_req_in),
    .cmd_code_out(cmd_code_in));
  pstu_param_store dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .power_up_in(power_up_in),
    .power_fail_in(power_fail_in), .wr_req_in(wr_req_in), .wr_id_in(wr_id_in),
    .wr_data_in(wr_data_in), .wr_class_in(wr_class_in), .rd_id_in(rd_id_in),
    .cmd_req_in(cmd_req_in), .cmd_code_in(cmd_code_in), .motor_run_in(motor_run_in),
    .alarm_in(alarm_in), .rd_data_out(rd_data_out), .wr_done_out(wr_done_out),
    .cmd_ack_out(cmd_ack_out), .cmd_rej_out(cmd_rej_out), .busy_out(busy_out),
    .setup_out(setup_out), .setup_class_out(setup_class_out),
    .alarm_code_out(alarm_code_out));
  initial forever #2 clk_in = ~clk_in;
  // ceiling holds two loads and two commits with room to spare
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares = miscompares + 1;
      final_report;
    end
  end
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks = checks + 1;
    if (g !== e) begin
      miscompares = miscompares + 1;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task final_report;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task tick(input integer n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  // bounded wait: a lost pulse fails a compare instead of hanging
  task wait_su(input logic [1:0] c);
    for (k = 0; k < 400 && setup_out !== 1'b1; k++) tick(1);
    chk("su", 1, setup_out);
    chk("cls", c, setup_class_out);
  endtask
  task do_cmd(input logic [15:0] c, input logic a);
    host.cmd(c);
    #1;
    chk("ack", a, cmd_ack_out);
    chk("rej", !a, cmd_rej_out);
  endtask
  initial begin
    repeat (12) @(posedge clk_in);
    rst_b_in <= 1'b1;
    wait_su(2'h3);
    for (k = 0; k < 400 && busy_out !== 1'b0; k++) tick(1);
    for (i = 0; i < 3; i++) begin
      host.wr(rows[i].id, rows[i].d, rows[i].c);
      #1;
      chk("done", 1, wr_done_out);
      chk("su", rows[i].su, setup_out);
      @(posedge clk_in) rd_id_in <= rows[i].id;
      tick(1);
      chk("rd", rows[i].d, rd_data_out);
    end
    $display("table done");
    @(posedge clk_in) motor_run_in <= 1'b1;
    host.wr(8'h20, 32'hBEEF_0001, 2'h1);
    #1;
    chk("su", 0, setup_out);
    do_cmd(16'h00C6, 0);
    @(posedge clk_in) motor_run_in <= 1'b0;
    wait_su(2'h1);
    tick(3);
    chk("su", 0, setup_out);
    @(posedge clk_in) alarm_in <= 1'b1;
    do_cmd(16'h00C6, 0);
    @(posedge clk_in) alarm_in <= 1'b0;
    do_cmd(16'h00C6, 1);
    chk("cls", 2'h2, setup_class_out);
    $display("deferred done");
    do_cmd(16'h00C9, 1);
    chk("busy", 1, busy_out);
    do_cmd(16'h00C6, 0);
    for (k = 0; k < 400 && busy_out !== 1'b0; k++) tick(1);
    chk("busy", 0, busy_out);
    host.wr(8'hFF, 32'h0000_5A5A, 2'h0);
    #1;
    chk("done", 1, wr_done_out);
    do_cmd(16'h00C9, 1);
    tick(20);
    @(posedge clk_in) power_fail_in <= 1'b1;
    tick(8);
    chk("alarm", 8'h41, alarm_code_out);
    $display("commit done");
    @(posedge clk_in) rst_b_in <= 1'b0;
    @(posedge clk_in) power_fail_in <= 1'b0;
    repeat (12) @(posedge clk_in);
    rst_b_in <= 1'b1;
    tick(2);
    chk("alarm", 8'h00, alarm_code_out);
    wait_su(2'h3);
    @(posedge clk_in) rd_id_in <= 8'h10;
    tick(1);
    chk("rd", 32'h1234_5678, rd_data_out);
    @(posedge clk_in) rd_id_in <= 8'hFF;
    tick(1);
    chk("rd", 32'hA5A5_5A5A, rd_data_out);
    $display("power cycle done");
    final_report;
  end
endmodule // testbench
